// File: common/aslf_pkg.sv
// Purpose: Constants for the serial link framing setup block
// Assumes: 8-bit register data, 16-bit register addresses
// Notes:   Register offsets are byte addresses on the control port
package aslf_pkg;
	localparam logic [15:0] ADDR_SOFT_RESET      = 16'h0000;
	localparam logic [15:0] ADDR_DATAPATH_RESET  = 16'h0001;
	localparam logic [15:0] ADDR_POWER_MODE      = 16'h0002;
	localparam logic [15:0] ADDR_BANDWIDTH_MODE  = 16'h0200;
	localparam logic [15:0] ADDR_DECIMATION      = 16'h0201;
	localparam logic [15:0] ADDR_LINK_MODE       = 16'h0570;
	localparam logic [15:0] ADDR_LINK_POWER      = 16'h0571;
	localparam logic [15:0] ADDR_SAMPLE_WIDTH    = 16'h058B;
	localparam logic [15:0] ADDR_SUBCLASS_RES    = 16'h058F;
	localparam logic [15:0] ADDR_SER_PLL         = 16'h1222;
	localparam logic [15:0] ADDR_LINK_STARTUP    = 16'h1228;
	localparam logic [15:0] ADDR_LOCK_CLEAR      = 16'h1262;
	// Values that carry meaning
	localparam logic [7:0] VAL_SOFT_RESET        = 8'h81;
	localparam logic [7:0] VAL_DATAPATH_RESET    = 8'h02;
	localparam logic [7:0] VAL_PACK_MODE         = 8'hFE;
	localparam logic [7:0] VAL_LINK_PWR_DOWN     = 8'h15;
	localparam logic [7:0] VAL_LINK_PWR_UP       = 8'h14;
	localparam logic [7:0] VAL_FULL_BANDWIDTH    = 8'h00;
	localparam logic [7:0] VAL_STARTUP_HOLD      = 8'h4F;
	localparam logic [7:0] VAL_STARTUP_RUN       = 8'h0F;
	localparam logic [7:0] VAL_PLL_CAL_RESET     = 8'h04;
	localparam logic [7:0] VAL_PLL_NORMAL        = 8'h00;
	localparam logic [7:0] VAL_LOCK_CLEAR        = 8'h08;
	localparam logic [7:0] VAL_LOCK_NORMAL       = 8'h00;
	localparam logic [1:0] POWER_ON_BITS         = 2'h0;
	// Reset values
	localparam logic [7:0] RST_ZERO              = 8'h00;
	localparam logic [7:0] RST_DECIMATION        = 8'h01;
	localparam logic [7:0] RST_LINK_MODE         = 8'h00;
	localparam logic [7:0] RST_LINK_POWER        = 8'h14;
	localparam logic [7:0] RST_SAMPLE_WIDTH      = 8'h0F;
	localparam logic [7:0] RST_SUBCLASS_RES      = 8'h2F;
	localparam logic [7:0] RST_STARTUP           = 8'h0F;
	// Packing layout
	localparam int SAMPLE_BITS  = 12;
	localparam int SAMPLES_PER_FRAME = 5;
	localparam int FRAME_BITS   = 64;
	localparam int SPARE_BITS   = 4;
	localparam logic [3:0] SPARE_VALUE = 4'h0;
	localparam logic [2:0] LAST_SLOT   = 3'h4;
	// Link parameters in packing mode
	localparam logic [3:0] PACK_L  = 4'h8;
	localparam logic [3:0] PACK_M  = 4'h2;
	localparam logic [4:0] PACK_NP = 5'h10;
	// Lane rate to sample rate ratio in packing mode
	localparam logic [3:0] PACK_RATE_RATIO = 4'h4;
	typedef enum logic [1:0] {
		ST_STARTUP_HOLD = 2'b00,
		ST_PLL_CAL      = 2'b01,
		ST_RUN          = 2'b10
	} aslf_link_state_e;
endpackage : aslf_pkg

// File: verilog/aslf_top.sv
// Purpose: Framing setup and fs x4 sample packer of the serial link
// Assumes: Register port writes are single-cycle strobes on CLOCK
// Notes:   Lane rate factor out is M*N'*10/(8*L) in units of output_sample_rate, PACK_RATE_RATIO in packing mode
`timescale 1ns/10ps
module aslf_top
	import aslf_pkg::*;
(
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	input  wire logic        REG_WRITE,
	input  wire logic [15:0] REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	output logic [7:0]       REG_RDATA,
	input  wire logic        POWER_DOWN_PIN,
	input  wire logic        PLL_LOCK_IN,
	input  wire logic        DDC_ACTIVE,
	input  wire logic        SAMPLE_VALID,
	output logic             SAMPLE_READY,
	input  wire logic [11:0] SAMPLE_DATA,
	output logic             FRAME_VALID,
	input  wire logic        FRAME_READY,
	output logic [63:0]      FRAME_DATA,
	output logic             PACK_MODE_ACTIVE,
	output logic             INIT_REQUIRED,
	output logic             LINK_RUNNING,
	output logic             LOSS_OF_LOCK,
	output logic [7:0]       DECIMATION_RATIO,
	output logic [3:0]       LANE_COUNT,
	output logic [3:0]       CONVERTER_COUNT,
	output logic [7:0]       LANE_RATE_FACTOR
);
	logic [7:0]       soft_reset_ctrl_reg;
	logic [7:0]       datapath_reset_ctrl_reg;
	logic [7:0]       power_mode_ctrl_reg;
	logic [7:0]       chip_bandwidth_mode_reg;
	logic [7:0]       decimation_select_reg;
	logic [7:0]       link_mode_select_reg;
	logic [7:0]       link_power_ctrl_reg;
	logic [7:0]       sample_width_ctrl_bits_reg;
	logic [7:0]       subclass_resolution_ctrl_reg;
	logic [7:0]       serializer_pll_ctrl_reg;
	logic [7:0]       link_startup_ctrl_reg;
	logic [7:0]       lock_loss_clear_ctrl_reg;
	logic [2:0]       power_down_pin_sync_reg;
	logic             power_down_pin_state_reg;
	logic [2:0]       lock_sync_reg;
	logic             lock_state_reg;
	logic             lol_reg;
	logic             init_req_reg;
	aslf_link_state_e state_reg;
	aslf_link_state_e state_next;
	logic [2:0]       slot_reg;
	logic [59:0]      accum_reg;
	logic [63:0]      buf_data_reg [2];
	logic             buf_wr_reg;
	logic             buf_rd_reg;
	logic [1:0]       buf_count_reg;
	logic             pack_ok;
	logic             frame_done;
	logic             buf_push;
	logic             buf_pop;
	logic             reset_event;
	logic             pll_cal;
	logic             wr_startup;
	logic             wr_pll;
	logic [5:0]       rate_mult;

	// Write strobes for the link bring-up registers
	assign wr_startup = REG_WRITE && (REG_ADDR == ADDR_LINK_STARTUP);
	assign wr_pll     = REG_WRITE && (REG_ADDR == ADDR_SER_PLL);

	// Register file writes
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			soft_reset_ctrl_reg          <= RST_ZERO;
			datapath_reset_ctrl_reg      <= RST_ZERO;
			power_mode_ctrl_reg          <= RST_ZERO;
			chip_bandwidth_mode_reg      <= RST_ZERO;
			decimation_select_reg        <= RST_DECIMATION;
			link_mode_select_reg         <= RST_LINK_MODE;
			link_power_ctrl_reg          <= RST_LINK_POWER;
			sample_width_ctrl_bits_reg   <= RST_SAMPLE_WIDTH;
			subclass_resolution_ctrl_reg <= RST_SUBCLASS_RES;
			serializer_pll_ctrl_reg      <= RST_ZERO;
			link_startup_ctrl_reg        <= RST_STARTUP;
			lock_loss_clear_ctrl_reg     <= RST_ZERO;
		end else if (REG_WRITE) begin
			if (REG_ADDR == ADDR_SOFT_RESET) begin
				soft_reset_ctrl_reg <= REG_WDATA;
			end else if (REG_ADDR == ADDR_DATAPATH_RESET) begin
				datapath_reset_ctrl_reg <= REG_WDATA;
			end else if (REG_ADDR == ADDR_POWER_MODE) begin
				power_mode_ctrl_reg <= REG_WDATA;
			end else if (REG_ADDR == ADDR_BANDWIDTH_MODE) begin
				chip_bandwidth_mode_reg <= REG_WDATA;
			end else if (REG_ADDR == ADDR_DECIMATION) begin
				decimation_select_reg <= REG_WDATA;
			end else if (REG_ADDR == ADDR_LINK_MODE) begin
				link_mode_select_reg <= REG_WDATA;
			end else if (REG_ADDR == ADDR_LINK_POWER) begin
				link_power_ctrl_reg <= REG_WDATA;
			end else if (REG_ADDR == ADDR_SAMPLE_WIDTH) begin
				sample_width_ctrl_bits_reg <= REG_WDATA;
			end else if (REG_ADDR == ADDR_SUBCLASS_RES) begin
				subclass_resolution_ctrl_reg <= REG_WDATA;
			end else if (REG_ADDR == ADDR_SER_PLL) begin
				serializer_pll_ctrl_reg <= REG_WDATA;
			end else if (REG_ADDR == ADDR_LINK_STARTUP) begin
				link_startup_ctrl_reg <= REG_WDATA;
			end else if (REG_ADDR == ADDR_LOCK_CLEAR) begin
				lock_loss_clear_ctrl_reg <= REG_WDATA;
			end
		end
	end

	// Register read mux, unmapped reads as zero
	always_comb begin
		REG_RDATA = RST_ZERO;
		if (REG_ADDR == ADDR_SOFT_RESET) begin
			REG_RDATA = soft_reset_ctrl_reg;
		end else if (REG_ADDR == ADDR_DATAPATH_RESET) begin
			REG_RDATA = datapath_reset_ctrl_reg;
		end else if (REG_ADDR == ADDR_POWER_MODE) begin
			REG_RDATA = power_mode_ctrl_reg;
		end else if (REG_ADDR == ADDR_BANDWIDTH_MODE) begin
			REG_RDATA = chip_bandwidth_mode_reg;
		end else if (REG_ADDR == ADDR_DECIMATION) begin
			REG_RDATA = decimation_select_reg;
		end else if (REG_ADDR == ADDR_LINK_MODE) begin
			REG_RDATA = link_mode_select_reg;
		end else if (REG_ADDR == ADDR_LINK_POWER) begin
			REG_RDATA = link_power_ctrl_reg;
		end else if (REG_ADDR == ADDR_SAMPLE_WIDTH) begin
			REG_RDATA = sample_width_ctrl_bits_reg;
		end else if (REG_ADDR == ADDR_SUBCLASS_RES) begin
			REG_RDATA = subclass_resolution_ctrl_reg;
		end else if (REG_ADDR == ADDR_SER_PLL) begin
			REG_RDATA = serializer_pll_ctrl_reg;
		end else if (REG_ADDR == ADDR_LINK_STARTUP) begin
			REG_RDATA = {link_startup_ctrl_reg[7:4], lol_reg, state_reg, LINK_RUNNING};
		end else if (REG_ADDR == ADDR_LOCK_CLEAR) begin
			REG_RDATA = {lock_loss_clear_ctrl_reg[7:1], lol_reg};
		end
	end

	// Pin synchronisers, change taken when stages two and three agree
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			power_down_pin_sync_reg  <= 3'h0;
			power_down_pin_state_reg <= 1'b0;
			lock_sync_reg  <= 3'h0;
			lock_state_reg <= 1'b0;
		end else begin
			power_down_pin_sync_reg <= {power_down_pin_sync_reg[1:0], POWER_DOWN_PIN};
			lock_sync_reg <= {lock_sync_reg[1:0], PLL_LOCK_IN};
			if (power_down_pin_sync_reg[1] == power_down_pin_sync_reg[2]) begin
				power_down_pin_state_reg <= power_down_pin_sync_reg[2];
			end
			if (lock_sync_reg[1] == lock_sync_reg[2]) begin
				lock_state_reg <= lock_sync_reg[2];
			end
		end
	end

	// Any reset kind that calls for the link init writes again
	assign reset_event =
		(power_down_pin_state_reg && !(power_down_pin_sync_reg[1] || power_down_pin_sync_reg[2])) ||
		(REG_WRITE && (REG_ADDR == ADDR_SOFT_RESET) && (REG_WDATA == VAL_SOFT_RESET)) ||
		(REG_WRITE && (REG_ADDR == ADDR_DATAPATH_RESET) &&
			(REG_WDATA == VAL_DATAPATH_RESET)) ||
		(REG_WRITE && (REG_ADDR == ADDR_POWER_MODE) && (REG_WDATA[1:0] == POWER_ON_BITS)) ||
		(REG_WRITE && (REG_ADDR == ADDR_LINK_POWER) && (REG_WDATA == VAL_LINK_PWR_UP) &&
			(link_power_ctrl_reg == VAL_LINK_PWR_DOWN));

	// Init-required flag, set wins over the clear on the start-up hold write
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			init_req_reg <= 1'b1;
		end else if (reset_event) begin
			init_req_reg <= 1'b1;
		end else if (wr_startup && (REG_WDATA == VAL_STARTUP_HOLD)) begin
			init_req_reg <= 1'b0;
		end
	end

	// Link bring-up state: start-up hold, PLL calibration, run
	always_comb begin
		pll_cal    = (serializer_pll_ctrl_reg == VAL_PLL_CAL_RESET);
		state_next = state_reg;
		case (state_reg)
			ST_STARTUP_HOLD: begin
				if (link_startup_ctrl_reg == VAL_STARTUP_RUN) begin
					state_next = ST_RUN;
				end
			end
			ST_PLL_CAL: begin
				if (!pll_cal) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (pll_cal) begin
					state_next = ST_PLL_CAL;
				end
			end
			default: state_next = ST_STARTUP_HOLD;
		endcase
		if (link_startup_ctrl_reg == VAL_STARTUP_HOLD) begin
			state_next = ST_STARTUP_HOLD;
		end
	end

	// State register
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			state_reg <= ST_STARTUP_HOLD;
		end else begin
			state_reg <= state_next;
		end
	end

	// Latched loss of lock; detection is held off while the clear value stands
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			lol_reg <= 1'b0;
		end else if ((state_reg == ST_RUN) && !lock_state_reg &&
			(lock_loss_clear_ctrl_reg != VAL_LOCK_CLEAR)) begin
			lol_reg <= 1'b1;
		end else if (lock_loss_clear_ctrl_reg == VAL_LOCK_CLEAR) begin
			lol_reg <= 1'b0;
		end
	end

	// Packing allowed only in full bandwidth with the link running
	assign pack_ok = (link_mode_select_reg == VAL_PACK_MODE) &&
		(chip_bandwidth_mode_reg == VAL_FULL_BANDWIDTH) && !DDC_ACTIVE &&
		(state_reg == ST_RUN) && !init_req_reg;

	// Sample packer stalls while the buffer is full
	assign SAMPLE_READY = pack_ok && (buf_count_reg != 2'h2);
	assign frame_done   = SAMPLE_READY && SAMPLE_VALID && (slot_reg == LAST_SLOT);
	assign buf_push     = frame_done;
	assign buf_pop      = FRAME_VALID && FRAME_READY;

	// Shift five samples in, oldest ending in the top bits
	always_ff @(posedge CLOCK) begin
		if (RESET || !pack_ok) begin
			slot_reg  <= 3'h0;
			accum_reg <= 60'h0;
		end else if (SAMPLE_READY && SAMPLE_VALID) begin
			accum_reg <= {accum_reg[47:0], SAMPLE_DATA};
			slot_reg  <= (slot_reg == LAST_SLOT) ? 3'h0 : slot_reg + 3'h1;
		end
	end

	// Two-entry frame buffer toward the lanes
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			buf_wr_reg      <= 1'b0;
			buf_rd_reg      <= 1'b0;
			buf_count_reg   <= 2'h0;
			buf_data_reg[0] <= 64'h0;
			buf_data_reg[1] <= 64'h0;
		end else begin
			if (buf_push) begin
				buf_data_reg[buf_wr_reg] <= {accum_reg[47:0], SAMPLE_DATA, SPARE_VALUE};
				buf_wr_reg <= !buf_wr_reg;
			end
			if (buf_pop) begin
				buf_rd_reg <= !buf_rd_reg;
			end
			buf_count_reg <= buf_count_reg + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end

	// Frame outputs
	assign FRAME_VALID = (buf_count_reg != 2'h0);
	assign FRAME_DATA  = buf_data_reg[buf_rd_reg];

	// One link for all lanes; fixed set in packing mode
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			LANE_COUNT      <= PACK_L;
			CONVERTER_COUNT <= PACK_M;
		end else if (link_mode_select_reg == VAL_PACK_MODE) begin
			LANE_COUNT      <= PACK_L;
			CONVERTER_COUNT <= PACK_M;
		end
	end

	// Lane rate factor M*N'*10/8/L; fixed PACK_RATE_RATIO in packing mode
	assign rate_mult = 6'(CONVERTER_COUNT) * 6'h2;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			LANE_RATE_FACTOR <= 8'h0;
		end else if (link_mode_select_reg == VAL_PACK_MODE) begin
			LANE_RATE_FACTOR <= {4'h0, PACK_RATE_RATIO};
		end else if ((LANE_COUNT == 4'h1) || (LANE_COUNT == 4'h2) || (LANE_COUNT == 4'h4) ||
			(LANE_COUNT == PACK_L)) begin
			// Widened so the product M*N'*10 does not wrap before the divide
			LANE_RATE_FACTOR <= 8'((16'(CONVERTER_COUNT) * 16'(PACK_NP) * 16'hA) /
				(16'(LANE_COUNT) * 16'h8));
		end
	end

	// Status outputs
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			PACK_MODE_ACTIVE <= 1'b0;
			INIT_REQUIRED    <= 1'b1;
			LINK_RUNNING     <= 1'b0;
			LOSS_OF_LOCK     <= 1'b0;
			DECIMATION_RATIO <= RST_DECIMATION;
		end else begin
			PACK_MODE_ACTIVE <= pack_ok;
			INIT_REQUIRED    <= init_req_reg;
			LINK_RUNNING     <= (state_next == ST_RUN);
			LOSS_OF_LOCK     <= lol_reg;
			DECIMATION_RATIO <= decimation_select_reg;
		end
	end

	logic unused_ok;
	assign unused_ok = wr_startup ^ wr_pll ^ rate_mult[0];
endmodule : aslf_top

// File: testbench/aslf_frame_sink.sv
// Purpose: Receiver side model that takes packed frames off the link
// Assumes: Ready changes only just after a rising clock edge
// Notes:   Toggles ready every cycle while not stalled so the buffer sees slow answers
`timescale 1ns/10ps
module aslf_frame_sink (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        stall,
	input  wire logic        valid,
	input  wire logic [63:0] data,
	output logic             ready
);
	logic [63:0] q[$];
	// Slow receiver: ready every other cycle, held low while stalled
	always_ff @(posedge clk) begin
		ready <= !rst && !stall && !ready;
	end
	// Keep every frame taken so the bench can compare them
	always @(posedge clk) begin
		if (!rst && valid && ready) begin
			q.push_back(data);
		end
	end
endmodule : aslf_frame_sink

// File: testbench/aslf_top_chk.sv
// Purpose: Port level checks of the link framing setup block
// Assumes: Single clock domain, synchronous active high reset
// Notes:   Bound to the top module from the bench top file
`timescale 1ns/10ps
module aslf_top_chk
	import aslf_pkg::*;
(
	input wire logic        CLOCK,
	input wire logic        RESET,
	input wire logic        REG_WRITE,
	input wire logic [15:0] REG_ADDR,
	input wire logic [7:0]  REG_WDATA,
	input wire logic        DDC_ACTIVE,
	input wire logic        SAMPLE_READY,
	input wire logic        FRAME_VALID,
	input wire logic        FRAME_READY,
	input wire logic [63:0] FRAME_DATA,
	input wire logic        PACK_MODE_ACTIVE,
	input wire logic        INIT_REQUIRED,
	input wire logic        LINK_RUNNING,
	input wire logic        LOSS_OF_LOCK,
	input wire logic [7:0]  DECIMATION_RATIO,
	input wire logic [3:0]  LANE_COUNT,
	input wire logic [3:0]  CONVERTER_COUNT,
	input wire logic [7:0]  LANE_RATE_FACTOR
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);
	// One register write of a given value
	sequence s_wr(logic [15:0] a, logic [7:0] d);
		REG_WRITE && REG_ADDR == a && REG_WDATA == d;
	endsequence
	// Frame offered and not taken
	sequence s_frame_waits;
		FRAME_VALID && !FRAME_READY;
	endsequence
	a_frame_spare: assert property (FRAME_VALID |-> FRAME_DATA[3:0] == SPARE_VALUE)
		else $error("spare bits of frame not zero");
	a_frame_hold: assert property (s_frame_waits |=> FRAME_VALID && $stable(FRAME_DATA))
		else $error("frame changed while stalled");
	a_pack_rate: assert property (PACK_MODE_ACTIVE |-> LANE_RATE_FACTOR == PACK_RATE_RATIO)
		else $error("lane rate factor wrong in packing mode");
	a_link_shape: assert property (LANE_COUNT == PACK_L && CONVERTER_COUNT == PACK_M)
		else $error("lane or converter count wrong");
	a_ddc_block: assert property (DDC_ACTIVE |-> !SAMPLE_READY)
		else $error("samples taken with downconverter active");
	a_soft_reset: assert property (s_wr(ADDR_SOFT_RESET, VAL_SOFT_RESET) |=> ##1 INIT_REQUIRED)
		else $error("soft reset did not request init");
	a_startup_hold: assert property (s_wr(ADDR_LINK_STARTUP, VAL_STARTUP_HOLD) |=> ##1 !LINK_RUNNING)
		else $error("link still running in start-up hold");
	a_pll_cal: assert property (s_wr(ADDR_SER_PLL, VAL_PLL_CAL_RESET) |=> ##1 !LINK_RUNNING)
		else $error("link still running in calibration");
	a_lock_clear: assert property (s_wr(ADDR_LOCK_CLEAR, VAL_LOCK_CLEAR) |=> ##2 !LOSS_OF_LOCK)
		else $error("loss of lock not cleared");
	a_dec_copy: assert property (REG_WRITE && REG_ADDR == ADDR_DECIMATION |=>
		##1 DECIMATION_RATIO == $past(REG_WDATA, 2))
		else $error("decimation ratio not copied");
endmodule : aslf_top_chk

// File: testbench/aslf_top_tb.sv
// Purpose: Self-checking bench for the link framing setup block
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Frames are gathered by the receiver model
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module aslf_top_tb;
	import aslf_pkg::*;
	logic        clock = 0, reset = 1, reg_write = 0, power_down_pin = 0, lock = 1, ddc = 0;
	logic        s_valid = 0, stall = 0;
	logic [15:0] reg_addr = 0;
	logic [7:0]  reg_wdata = 0;
	logic [11:0] s_data = 0;
	logic        s_ready, f_valid, f_ready, pack, init_req, running, lol;
	logic [63:0] f_data;
	logic [7:0]  rdata, dec, lrf;
	logic [3:0]  lanes, convs;
	int          err_count = 0, total_checks = 0, cycles = 0;
	logic [23:0] init_seq [7] = '{24'h12284F, 24'h12280F, 24'h122200, 24'h122204,
		24'h122200, 24'h126208, 24'h126200};
	aslf_top DUT (.CLOCK(clock), .RESET(reset), .REG_WRITE(reg_write), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_RDATA(rdata), .POWER_DOWN_PIN(power_down_pin), .PLL_LOCK_IN(lock),
		.DDC_ACTIVE(ddc), .SAMPLE_VALID(s_valid), .SAMPLE_READY(s_ready), .SAMPLE_DATA(s_data),
		.FRAME_VALID(f_valid), .FRAME_READY(f_ready), .FRAME_DATA(f_data),
		.PACK_MODE_ACTIVE(pack), .INIT_REQUIRED(init_req), .LINK_RUNNING(running),
		.LOSS_OF_LOCK(lol), .DECIMATION_RATIO(dec), .LANE_COUNT(lanes),
		.CONVERTER_COUNT(convs), .LANE_RATE_FACTOR(lrf));
	aslf_frame_sink sink (.clk(clock), .rst(reset), .stall(stall), .valid(f_valid),
		.data(f_data), .ready(f_ready));
	// Clock and hang guard
	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim
	task automatic cyc(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge clock);
		#1 reg_write = 1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clock);
		#1 reg_write = 0;
	endtask : wr
	task automatic rd(logic [15:0] a, logic [7:0] e);
		reg_addr = a;
		cyc(1);
		`CHK(rdata, e)
	endtask : rd
	task automatic put(logic [11:0] s);
		s_valid = 1;
		s_data = s;
		for (int n = 0; n < 50 && !s_ready; n++) cyc(1);
		`CHK(s_ready, 1'b1)
		cyc(1);
	endtask : put
	task automatic init_link();
		foreach (init_seq[i]) wr(init_seq[i][23:8], init_seq[i][7:0]);
		cyc(2);
		`CHK(init_req, 1'b0)
		`CHK(running, 1'b1)
	endtask : init_link
	function automatic logic [11:0] smp(int k);
		return 12'(k * 12'h135 + 12'hA5C);
	endfunction : smp
	initial begin
		cyc(12);
		reset = 0;
		// Reset values
		`CHK(init_req, 1'b1)
		`CHK({lanes, convs}, 8'h82)
		rd(ADDR_DECIMATION, 8'h01);
		rd(ADDR_LINK_POWER, 8'h14);
		rd(16'h0FFF, 8'h00);
		`CHK(lrf, 8'h05)
		$display("test reset values done");
		// Packing mode entry and bring-up
		wr(ADDR_LINK_POWER, VAL_LINK_PWR_DOWN);
		wr(ADDR_LINK_MODE, VAL_PACK_MODE);
		wr(ADDR_SAMPLE_WIDTH, 8'h0F);
		wr(ADDR_SUBCLASS_RES, 8'h2F);
		wr(ADDR_BANDWIDTH_MODE, VAL_FULL_BANDWIDTH);
		wr(16'h056E, 8'h30);
		wr(ADDR_LINK_POWER, VAL_LINK_PWR_UP);
		rd(ADDR_LINK_MODE, 8'hFE);
		rd(ADDR_SUBCLASS_RES, 8'h2F);
		init_link();
		cyc(2);
		`CHK(pack, 1'b1)
		`CHK(lrf, 8'h04)
		$display("test bring-up done");
		// Fill the buffer against a stalled receiver, then drain
		stall = 1;
		for (int k = 0; k < 10; k++) put(smp(k));
		s_valid = 0;
		cyc(3);
		`CHK(s_ready, 1'b0)
		stall = 0;
		for (int k = 10; k < 15; k++) put(smp(k));
		s_valid = 0;
		for (int n = 0; n < 100 && sink.q.size() < 3; n++) cyc(1);
		for (int f = 0; f < 3; f++) begin
			`CHK(sink.q[f], {smp(5*f), smp(5*f+1), smp(5*f+2), smp(5*f+3), smp(5*f+4), 4'h0})
		end
		ddc = 1;
		cyc(2);
		`CHK(s_ready, 1'b0)
		ddc = 0;
		$display("test packing done");
		// Loss of lock latch and clear, PLL calibration, decimation
		lock = 0;
		for (int n = 0; n < 10 && !lol; n++) cyc(1);
		lock = 1;
		cyc(5);
		`CHK(lol, 1'b1)
		rd(ADDR_LOCK_CLEAR, 8'h01);
		wr(ADDR_LOCK_CLEAR, VAL_LOCK_CLEAR);
		cyc(2);
		`CHK(lol, 1'b0)
		wr(ADDR_LOCK_CLEAR, VAL_LOCK_NORMAL);
		wr(ADDR_SER_PLL, VAL_PLL_CAL_RESET);
		cyc(1);
		`CHK(running, 1'b0)
		wr(ADDR_SER_PLL, VAL_PLL_NORMAL);
		cyc(2);
		`CHK(running, 1'b1)
		wr(ADDR_DECIMATION, 8'h08);
		cyc(1);
		`CHK(dec, 8'h08)
		$display("test lock and pll done");
		// Every event that asks for the init sequence again
		for (int i = 0; i < 5; i++) begin
			case (i)
				0: wr(ADDR_SOFT_RESET, VAL_SOFT_RESET);
				1: wr(ADDR_DATAPATH_RESET, VAL_DATAPATH_RESET);
				2: begin wr(ADDR_POWER_MODE, 8'h01); wr(ADDR_POWER_MODE, 8'h00); end
				3: begin wr(ADDR_LINK_POWER, VAL_LINK_PWR_DOWN); wr(ADDR_LINK_POWER, VAL_LINK_PWR_UP); end
				default: begin power_down_pin = 1; cyc(5); power_down_pin = 0; end
			endcase
			cyc(6);
			`CHK(init_req, 1'b1)
			init_link();
		end
		$display("test re-init done");
		end_sim();
	end
endmodule : aslf_top_tb
bind aslf_top aslf_top_chk chk (.CLOCK(CLOCK), .RESET(RESET), .REG_WRITE(REG_WRITE),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .DDC_ACTIVE(DDC_ACTIVE),
	.SAMPLE_READY(SAMPLE_READY), .FRAME_VALID(FRAME_VALID), .FRAME_READY(FRAME_READY),
	.FRAME_DATA(FRAME_DATA), .PACK_MODE_ACTIVE(PACK_MODE_ACTIVE),
	.INIT_REQUIRED(INIT_REQUIRED), .LINK_RUNNING(LINK_RUNNING), .LOSS_OF_LOCK(LOSS_OF_LOCK),
	.DECIMATION_RATIO(DECIMATION_RATIO), .LANE_COUNT(LANE_COUNT),
	.CONVERTER_COUNT(CONVERTER_COUNT), .LANE_RATE_FACTOR(LANE_RATE_FACTOR));
